// [design/led_sink_serial_control.sv]
`timescale 1ns/100ps
`include "led_sink_defs.svh"

// Notes on behaviour
// - Blank high forces every output to precharge.
// - Mode pin selects on/off or correction logic.
// - Shift clock rise shifts serial_in into selected register.
// - Error output pulls low on open LED or overtemp.
// - Mode low: latch rise copies on/off register.
// - Mode high: correction transparent while latch high.
// - Correction shift register is 112 bits.
// - Correction packet MSB first, channel 15 first.
// - Correction value scales current linearly, 127 full.
// - Latching works regardless of blank.
// - On/off shift register is 16 bits, MSB first.
// - Blank rise: staggered turn-off, then precharge on.
// - Blank fall: precharge off, sinks follow on/off bits.
// - Channel n delayed n times 20 ns.
// - Pending channels keep their own delayed times.
// - Precharge turns on after the CHANNELS+1 step drain, with all channels off.
// - Precharge turns off right after blank falls.
// - Serial out shows far end of active register.
// - Open LED needs blank low, bit set, low voltage.
// - Mode low: latch rise captures open-LED status.
// - Blank high masks open-LED from error output.
module led_sink_serial_control #(
  parameter int CHANNELS = `LS_CHANNELS,
  parameter int CORR_W = `LS_CORR_W
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic shift_clock_i,
  input wire logic serial_in_i,
  input wire logic latch_strobe_i,
  input wire logic mode_i,
  input wire logic output_blank_i,
  input wire logic overtemp_i,
  input wire logic [CHANNELS-1:0] out_low_i,
  output logic serial_out_o,
  output logic [CHANNELS-1:0] sink_on_o,
  output logic precharge_on_o,
  output logic [CHANNELS*CORR_W-1:0] channel_correction_value_o,
  output logic error_flag_n_o,
  output logic error_flag_n_oe_o,
  output logic [CHANNELS-1:0] open_led_flag_o,
  output logic overtemp_flag_o
);
  localparam int CBITS = CHANNELS * CORR_W;

  // Every pin passes two flip-flops; only the second stage is read.
  logic [6:0] pin_s1_r;
  logic [6:0] pin_s2_r;
  logic [CHANNELS-1:0] low_s1_r;
  logic [CHANNELS-1:0] low_s2_r;
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      // Blank leaves reset asserted, so releasing reset never looks like an unblank.
      pin_s1_r <= `LS_PIN_RST;
      pin_s2_r <= `LS_PIN_RST;
      low_s1_r <= '0;
      low_s2_r <= '0;
    end
    else
    begin
      pin_s1_r <= {overtemp_i, output_blank_i, mode_i, latch_strobe_i, serial_in_i,
                   shift_clock_i, 1'b0};
      pin_s2_r <= pin_s1_r;
      low_s1_r <= out_low_i;
      low_s2_r <= low_s1_r;
    end
  end

  logic sclk_s;
  logic sin_s;
  logic lat_s;
  logic mode_s;
  logic blank_s;
  logic ot_s;
  assign sclk_s = pin_s2_r[1];
  assign sin_s = pin_s2_r[2];
  assign lat_s = pin_s2_r[3];
  assign mode_s = pin_s2_r[4];
  assign blank_s = pin_s2_r[5];
  assign ot_s = pin_s2_r[6];

  logic sclk_d_r;
  logic lat_d_r;
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      sclk_d_r <= 1'b0;
      lat_d_r <= 1'b0;
    end
    else
    begin
      sclk_d_r <= sclk_s;
      lat_d_r <= lat_s;
    end
  end

  logic sclk_rise;
  logic lat_rise;
  assign sclk_rise = sclk_s & ~sclk_d_r;
  assign lat_rise = lat_s & ~lat_d_r;

  // Shift registers; mode steers clock and data to one of them.
  logic [CBITS-1:0] corr_shift_r;
  logic [CHANNELS-1:0] onoff_shift_r;
  logic [CHANNELS-1:0] open_latch_r;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
      corr_shift_r <= '0;
    else if (mode_s && sclk_rise && !lat_s)
      corr_shift_r <= {corr_shift_r[CBITS-2:0], sin_s};
  end

  // While the strobe is high in on/off mode, from the cycle after its rise, the open-LED latch holds the
  // register in set/reset, which outranks shifting.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
      onoff_shift_r <= '0;
    else if (!mode_s && lat_s && !lat_rise)
      onoff_shift_r <= open_latch_r;
    else if (!mode_s && sclk_rise && !lat_s)
      onoff_shift_r <= {onoff_shift_r[CHANNELS-2:0], sin_s};
  end

  assign serial_out_o = mode_s ? corr_shift_r[CBITS-1] : onoff_shift_r[CHANNELS-1];

  // Output registers accept data whatever the blank level.
  logic [CHANNELS-1:0] onoff_r;
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
      onoff_r <= '0;
    else if (!mode_s && lat_rise)
      onoff_r <= onoff_shift_r;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
      channel_correction_value_o <= '0;
    else if (mode_s && lat_s)
      channel_correction_value_o <= corr_shift_r;
  end
  // Correction words feed the analog DAC: zero is off, full code is full scale.

  // Open-LED detection and its snapshot.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
      open_led_flag_o <= '0;
    else
      open_led_flag_o <= blank_s ? '0 : (onoff_r & low_s2_r);
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
      open_latch_r <= '0;
    else if (!mode_s && lat_rise)
      open_latch_r <= open_led_flag_o;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
      overtemp_flag_o <= 1'b0;
    else
      overtemp_flag_o <= ot_s;
  end

  // Open drain: the pin is only ever driven low.
  assign error_flag_n_o = 1'b0;
  assign error_flag_n_oe_o = overtemp_flag_o | (|open_led_flag_o);

  // Step divider gives the 20 ns delay base.
  logic [`LS_STEP_CW-1:0] step_cnt_r;
  logic step_en;
  assign step_en = (step_cnt_r == `LS_STEP_CW'(`LS_STEP_CYC - 1));
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
      step_cnt_r <= '0;
    else if (step_en)
      step_cnt_r <= '0;
    else
      step_cnt_r <= step_cnt_r + `LS_STEP_CW'(1);
  end

  // Requests enter the delay lines; each channel lags by its index.
  logic [CHANNELS-1:0] req;
  assign req = blank_s ? '0 : onoff_r;
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++)
    begin : g_ch
      chan_delay #(.DEPTH(g)) u_dly (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .step_i(step_en),
        .req_i(req[g]),
        .sink_o(sink_on_o[g])
      );
    end
  endgenerate

  logic pending_r;

  // Precharge phase machine.
  led_sink_pkg::phase_e phase_r;
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
      phase_r <= led_sink_pkg::PH_BLANKED;
    else
      unique case (phase_r)
        led_sink_pkg::PH_BLANKED:
          if (!blank_s)
            phase_r <= led_sink_pkg::PH_RUN;
        led_sink_pkg::PH_RUN:
          if (blank_s)
            phase_r <= led_sink_pkg::PH_DRAIN;
        led_sink_pkg::PH_DRAIN:
          if (!blank_s)
            phase_r <= led_sink_pkg::PH_RUN;
          else if (sink_on_o == '0 && req == '0 && pending_r == 1'b0)
            phase_r <= led_sink_pkg::PH_BLANKED;
      endcase
  end

  // Drain waits CHANNELS+1 steps, two more than the longest line, so that late turn-ons finish first.
  logic [`LS_STEP_CW+3:0] drain_cnt_r;
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
      drain_cnt_r <= '0;
    else if (phase_r != led_sink_pkg::PH_DRAIN)
      drain_cnt_r <= '0;
    else if (pending_r)
      drain_cnt_r <= drain_cnt_r + 1'b1;
  end
  always_comb
  begin
    pending_r = (drain_cnt_r < (`LS_STEP_CW+4)'((CHANNELS + 1) * `LS_STEP_CYC));
  end

  assign precharge_on_o = (phase_r == led_sink_pkg::PH_BLANKED);

  property p_blank_force;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      blank_s [*8] |-> ##[0:400] (precharge_on_o && sink_on_o == '0);
  endproperty
  a_blank_force: assert property (p_blank_force) else $error("blank did not force precharge");

  property p_onoff_latch;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (!mode_s && lat_rise) |=> onoff_r == $past(onoff_shift_r);
  endproperty
  a_onoff_latch: assert property (p_onoff_latch) else $error("on/off not latched");

  property p_corr_hold;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (!lat_s && !$past(lat_s)) |=> $stable(channel_correction_value_o);
  endproperty
  a_corr_hold: assert property (p_corr_hold) else $error("correction changed");

  property p_shift;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (mode_s && sclk_rise && !lat_s) |=> corr_shift_r[0] == $past(sin_s);
  endproperty
  a_shift: assert property (p_shift) else $error("bit not shifted");

  property p_err;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (ot_s) |-> ##1 error_flag_n_oe_o;
  endproperty
  a_err: assert property (p_err) else $error("overtemp not reported");

  property p_mask;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      blank_s |=> open_led_flag_o == '0;
  endproperty
  a_mask: assert property (p_mask) else $error("open LED not masked");

  property p_ch0;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      $rose(req[0]) |=> sink_on_o[0];
  endproperty
  a_ch0: assert property (p_ch0) else $error("channel 0 delayed");

  property p_pre_off;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (precharge_on_o && !blank_s) |=> !precharge_on_o;
  endproperty
  a_pre_off: assert property (p_pre_off) else $error("precharge stayed on");

  property p_pre_last;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      $rose(precharge_on_o) |-> sink_on_o == '0;
  endproperty
  a_pre_last: assert property (p_pre_last) else $error("precharge with sink on");

  property p_serial_out;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      !mode_s |-> serial_out_o == onoff_shift_r[CHANNELS-1];
  endproperty
  a_serial_out: assert property (p_serial_out) else $error("serial out wrong");

  property p_serial_out_corr;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      mode_s |-> serial_out_o == corr_shift_r[CBITS-1];
  endproperty
  a_serial_out_corr: assert property (p_serial_out_corr) else $error("serial out not correction");

  property p_onoff_shift;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (!mode_s && sclk_rise && !lat_s) |=> onoff_shift_r[0] == $past(sin_s);
  endproperty
  a_onoff_shift: assert property (p_onoff_shift) else $error("on/off not shifted");

  property p_corr_transp;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (mode_s && lat_s) |=> channel_correction_value_o == $past(corr_shift_r);
  endproperty
  a_corr_transp: assert property (p_corr_transp) else $error("correction not loaded");

  property p_lod_snap;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (!mode_s && lat_rise) |=> open_latch_r == $past(open_led_flag_o);
  endproperty
  a_lod_snap: assert property (p_lod_snap) else $error("open-LED not captured");

  property p_lod_load;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (!mode_s && lat_s && $past(lat_s)) |=> onoff_shift_r == $past(open_latch_r);
  endproperty
  a_lod_load: assert property (p_lod_load) else $error("open-LED not loaded");

  property p_lod_live;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      !blank_s |=> open_led_flag_o == ($past(onoff_r) & $past(low_s2_r));
  endproperty
  a_lod_live: assert property (p_lod_live) else $error("open-LED flag wrong");
endmodule

// [design/led_sink_defs.svh]
`ifndef LED_SINK_DEFS_SVH
`define LED_SINK_DEFS_SVH

// Channel count, correction word width and packet lengths.
`define LS_CHANNELS 16
`define LS_CORR_W 7
`define LS_CORR_BITS 112
`define LS_ONOFF_BITS 16
// Channel-to-channel switching step in ns, and the system clock period in ns.
`define LS_STEP_NS 20
`define LS_CLK_NS 10
// Cycles per step: the 20 ns step rounds down to whole 10 ns cycles, at least one.
`define LS_STEP_CYC ((`LS_STEP_NS / `LS_CLK_NS) < 1 ? 1 : (`LS_STEP_NS / `LS_CLK_NS))
`define LS_STEP_CW 4
`define LS_CORR_FULL 7'h7f
// Pin synchroniser reset value: the blank stage (bit 5) starts asserted.
`define LS_PIN_RST 7'h20

`endif

// [design/led_sink_pkg.sv]
package led_sink_pkg;
  typedef enum logic [1:0] {PH_BLANKED, PH_RUN, PH_DRAIN} phase_e;
  typedef logic [6:0] corr_t;
endpackage

// [design/chan_delay.sv]
`timescale 1ns/100ps
`include "led_sink_defs.svh"

// One channel's switching delay: the sink follows the request after
// a fixed number of steps, for both edges.
module chan_delay #(
  parameter int DEPTH = 0
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic step_i,
  input wire logic req_i,
  output logic sink_o
);
  generate
    if (DEPTH == 0)
    begin : g_none
      always_ff @(posedge clk_sys_i)
      begin
        if (!rstn_i)
          sink_o <= 1'b0;
        else
          sink_o <= req_i;
      end
    end
    else
    begin : g_line
      logic [DEPTH-1:0] line_r;
      logic [DEPTH:0] tap;
      // The request enters at the bottom tap, so a single stage needs no special case.
      assign tap = {line_r, req_i};
      always_ff @(posedge clk_sys_i)
      begin
        if (!rstn_i)
          line_r <= '0;
        else if (step_i)
          line_r <= tap[DEPTH-1:0];
      end
      always_ff @(posedge clk_sys_i)
      begin
        if (!rstn_i)
          sink_o <= 1'b0;
        else
          sink_o <= line_r[DEPTH-1];
      end
    end
  endgenerate
endmodule

// [tb/serial_ctrl_model.sv]
`timescale 1ns/100ps

// Controller on the serial port: shift clock rests low between packets.
module serial_ctrl_model (
  input wire logic clk_sys_i,
  output logic shift_clock_o,
  output logic serial_in_o,
  output logic latch_strobe_o,
  output logic mode_o
);
  initial
  begin
    shift_clock_o = 1'b0;
    serial_in_o = 1'b0;
    latch_strobe_o = 1'b0;
    mode_o = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask

  // The data line is inverted once it is no longer sampled, so a stale bit never looks valid.
  task automatic send(input logic [111:0] d, input int bits, input logic corr);
    mode_o = corr;
    wt(4);
    for (int i = bits - 1; i >= 0; i--)
    begin
      serial_in_o = d[i];
      wt(4);
      shift_clock_o = 1'b1;
      wt(4);
      shift_clock_o = 1'b0;
    end
    serial_in_o = ~serial_in_o;
    wt(4);
    latch_strobe_o = 1'b1;
    wt(4);
    latch_strobe_o = 1'b0;
    wt(4);
  endtask
endmodule

// [tb/testbench.sv]
`timescale 1ns/100ps

module testbench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic blank = 1'b1;
  logic ot = 1'b0;
  logic [15:0] low = 16'h0;
  logic sclk, serial_in, lat, mode, serial_out, pre, err_n, oe, otf;
  logic [15:0] sink, open_led_flag;
  logic [111:0] corr, pat;
  logic seen;
  int mismatches = 0;
  int n_compared = 0;

  always #5 clk = ~clk;

  led_sink_serial_control u_led_sink_serial_control (
    .clk_sys_i(clk), .rstn_i(rstn), .shift_clock_i(sclk), .serial_in_i(serial_in),
    .latch_strobe_i(lat), .mode_i(mode), .output_blank_i(blank), .overtemp_i(ot),
    .out_low_i(low), .serial_out_o(serial_out), .sink_on_o(sink), .precharge_on_o(pre),
    .channel_correction_value_o(corr), .error_flag_n_o(err_n),
    .error_flag_n_oe_o(oe), .open_led_flag_o(open_led_flag), .overtemp_flag_o(otf)
  );

  serial_ctrl_model u_serial_ctrl_model (
    .clk_sys_i(clk), .shift_clock_o(sclk), .serial_in_o(serial_in),
    .latch_strobe_o(lat), .mode_o(mode)
  );

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic chk(input logic [111:0] got, input logic [111:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    if (mismatches == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic t_corr;
    for (int n = 0; n < 16; n++)
      pat[n*7 +: 7] = 7'(n * 9 + 1);
    u_serial_ctrl_model.send(pat, 112, 1'b1);
    chk(corr, pat);
    chk(112'(serial_out), 112'(pat[111]));
  endtask

  task automatic t_onoff;
    u_serial_ctrl_model.send(112'ha5c3, 16, 1'b0);
    cyc(8);
    chk(112'({sink, pre}), 112'h1);
    chk(corr, pat);
    blank = 1'b0;
    cyc(12);
    chk(112'({sink[15], sink[0], pre}), 112'h2);
    cyc(40);
    chk(112'(sink), 112'ha5c3);
  endtask

  task automatic t_blank;
    blank = 1'b1;
    cyc(10);
    chk(112'({sink[15], sink[0], pre}), 112'h4);
    cyc(40);
    chk(112'({sink, pre}), 112'h1);
    blank = 1'b0;
    cyc(4);
    blank = 1'b1;
    seen = 1'b0;
    for (int i = 0; i < 60; i++)
    begin
      cyc(1);
      if (sink[15] === 1'b1)
        seen = 1'b1;
    end
    chk(112'(seen), 112'h1);
    chk(112'(pre), 112'h1);
  endtask

  task automatic t_err;
    ot = 1'b1;
    cyc(6);
    chk(112'({oe, otf, err_n}), 112'h6);
    ot = 1'b0;
    low = 16'h8001;
    cyc(6);
    chk(112'({oe, open_led_flag}), 112'h0);
    blank = 1'b0;
    cyc(60);
    chk(112'({oe, open_led_flag}), 112'h18001);
    u_serial_ctrl_model.send(112'h25c3, 16, 1'b0);
    chk(112'(serial_out), 112'h1);
    chk(112'(open_led_flag), 112'h1);
    low = 16'h0;
    cyc(6);
    chk(112'(oe), 112'h0);
  endtask

  initial
  begin
    cyc(3);
    chk(112'({sink, pre, oe}), 112'h2);
    rstn = 1'b1;
    cyc(3);
    t_corr();
    t_onoff();
    t_blank();
    t_err();
    conclude();
  end

  initial
  begin
    #100us;
    mismatches++;
    conclude();
  end
endmodule
